// ===== verilog/level_decay_pkg.sv
// Constants for the level release rate and coefficient staging register slice.
// Behaviour
// - The 12-bit release rate sets how fast earlier attack attenuation is removed.
// - The rate code is a per-sample coefficient scaled by two to the 23rd.
// - The release coefficient is applied once per tick of the system sample rate.
// - Each staged coefficient has a full 16-bit register for its upper sixteen bits.
// - Each companion register holds bits 3:0 of the coefficient; bits 15:4 read zero.
package level_decay_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int RATE_W = 12;
	localparam int LOW_W = 4;
	localparam int COEF_W = 20;
	localparam int ATTEN_W = 24;
	localparam int PROD_W = ATTEN_W + RATE_W;
	localparam int COEF_FRAC = 23;
	localparam logic [ADDR_W-1:0] ADDR_RELEASE_RATE = 16'h012a;
	localparam logic [ADDR_W-1:0] ADDR_B1_UPPER = 16'h012c;
	localparam logic [ADDR_W-1:0] ADDR_B1_LOWER = 16'h012e;
	localparam logic [ADDR_W-1:0] ADDR_B2_UPPER = 16'h0130;
	localparam logic [ADDR_W-1:0] ADDR_B2_LOWER = 16'h0132;
	localparam logic [ADDR_W-1:0] ADDR_A1_UPPER = 16'h0134;
	localparam logic [ADDR_W-1:0] ADDR_A1_LOWER = 16'h0136;
	localparam logic [ADDR_W-1:0] ADDR_A2_UPPER = 16'h0138;
	localparam logic [ADDR_W-1:0] ADDR_A2_LOWER = 16'h013a;
	localparam logic [ADDR_W-1:0] ADDR_ATTEN_STATUS = 16'h013c;
	localparam logic [RATE_W-1:0] RESET_RELEASE_RATE = 12'h050;
	localparam logic [DATA_W-1:0] RESET_UPPER = 16'h0000;
	localparam logic [LOW_W-1:0] RESET_LOWER = 4'h0;
	localparam logic [ATTEN_W-1:0] RESET_ATTEN = 24'h000000;
	localparam logic [DATA_W-1:0] READ_UNMAPPED = 16'h0000;
endpackage : level_decay_pkg

// ===== verilog/level_decay_and_coef_staging.sv
// Register slice holding the level release rate, its release engine and coefficient staging.
`timescale 1ns/10ps
`default_nettype none
module level_decay_and_coef_staging (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [level_decay_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [level_decay_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [level_decay_pkg::DATA_W-1:0] reg_rdata,
	input wire logic sample_tick,
	input wire logic atten_load,
	input wire logic [level_decay_pkg::ATTEN_W-1:0] atten_in,
	output logic [level_decay_pkg::ATTEN_W-1:0] atten_out,
	input wire logic coef_commit,
	output logic [level_decay_pkg::COEF_W-1:0] active_b1,
	output logic [level_decay_pkg::COEF_W-1:0] active_b2,
	output logic [level_decay_pkg::COEF_W-1:0] active_a1,
	output logic [level_decay_pkg::COEF_W-1:0] active_a2
);
	// Joins an upper half and its four low bits into one coefficient.
	function automatic logic [level_decay_pkg::COEF_W-1:0] join_coef(
		input logic [level_decay_pkg::DATA_W-1:0] upper,
		input logic [level_decay_pkg::LOW_W-1:0] lower
	);
		join_coef = {upper, lower};
	endfunction : join_coef

	// One release step: attenuation times the coefficient, shifted down by 23 bits.
	// The product never exceeds the attenuation, so the difference cannot wrap.
	function automatic logic [level_decay_pkg::ATTEN_W-1:0] release_step(
		input logic [level_decay_pkg::ATTEN_W-1:0] atten,
		input logic [level_decay_pkg::RATE_W-1:0] rate
	);
		logic [level_decay_pkg::PROD_W-1:0] prod;
		logic [level_decay_pkg::PROD_W-1:0] shifted;
		prod = {{level_decay_pkg::RATE_W{1'b0}}, atten} * {{level_decay_pkg::ATTEN_W{1'b0}}, rate};
		// Only the bits above the fraction survive; the shifted value is at most 13 bits wide.
		shifted = prod >> level_decay_pkg::COEF_FRAC;
		release_step = atten - shifted[level_decay_pkg::ATTEN_W-1:0];
	endfunction : release_step

	// Returns a low half as a full read word with the reserved bits at zero.
	function automatic logic [level_decay_pkg::DATA_W-1:0] low_word(
		input logic [level_decay_pkg::LOW_W-1:0] lower
	);
		low_word = {{(level_decay_pkg::DATA_W - level_decay_pkg::LOW_W){1'b0}}, lower};
	endfunction : low_word

	logic [level_decay_pkg::RATE_W-1:0] rate_q;
	logic [level_decay_pkg::DATA_W-1:0] b1_up_q;
	logic [level_decay_pkg::DATA_W-1:0] b2_up_q;
	logic [level_decay_pkg::DATA_W-1:0] a1_up_q;
	logic [level_decay_pkg::DATA_W-1:0] a2_up_q;
	logic [level_decay_pkg::LOW_W-1:0] b1_lo_q;
	logic [level_decay_pkg::LOW_W-1:0] b2_lo_q;
	logic [level_decay_pkg::LOW_W-1:0] a1_lo_q;
	logic [level_decay_pkg::LOW_W-1:0] a2_lo_q;
	logic [level_decay_pkg::ATTEN_W-1:0] atten_q;
	logic [level_decay_pkg::DATA_W-1:0] rdata_d;
	logic [level_decay_pkg::DATA_W-1:0] rdata_q;
	logic [level_decay_pkg::COEF_W-1:0] act_b1_q;
	logic [level_decay_pkg::COEF_W-1:0] act_b2_q;
	logic [level_decay_pkg::COEF_W-1:0] act_a1_q;
	logic [level_decay_pkg::COEF_W-1:0] act_a2_q;

	assign reg_rdata = rdata_q;
	assign atten_out = atten_q;
	assign active_b1 = act_b1_q;
	assign active_b2 = act_b2_q;
	assign active_a1 = act_a1_q;
	assign active_a2 = act_a2_q;

	// Release rate register; bits 15:12 are dropped and read back as zero.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rate_q <= level_decay_pkg::RESET_RELEASE_RATE;
		end else if (reg_wr && reg_addr == level_decay_pkg::ADDR_RELEASE_RATE) begin
			rate_q <= reg_wdata[level_decay_pkg::RATE_W-1:0];
		end
	end

	// Upper halves keep all sixteen bits.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			b1_up_q <= level_decay_pkg::RESET_UPPER;
			b2_up_q <= level_decay_pkg::RESET_UPPER;
			a1_up_q <= level_decay_pkg::RESET_UPPER;
			a2_up_q <= level_decay_pkg::RESET_UPPER;
		end else if (reg_wr) begin
			case (reg_addr)
				level_decay_pkg::ADDR_B1_UPPER: b1_up_q <= reg_wdata;
				level_decay_pkg::ADDR_B2_UPPER: b2_up_q <= reg_wdata;
				level_decay_pkg::ADDR_A1_UPPER: a1_up_q <= reg_wdata;
				level_decay_pkg::ADDR_A2_UPPER: a2_up_q <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// Lower halves store only bits 3:0; writes to the reserved bits are ignored.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			b1_lo_q <= level_decay_pkg::RESET_LOWER;
			b2_lo_q <= level_decay_pkg::RESET_LOWER;
			a1_lo_q <= level_decay_pkg::RESET_LOWER;
			a2_lo_q <= level_decay_pkg::RESET_LOWER;
		end else if (reg_wr) begin
			case (reg_addr)
				level_decay_pkg::ADDR_B1_LOWER: b1_lo_q <= reg_wdata[level_decay_pkg::LOW_W-1:0];
				level_decay_pkg::ADDR_B2_LOWER: b2_lo_q <= reg_wdata[level_decay_pkg::LOW_W-1:0];
				level_decay_pkg::ADDR_A1_LOWER: a1_lo_q <= reg_wdata[level_decay_pkg::LOW_W-1:0];
				level_decay_pkg::ADDR_A2_LOWER: a2_lo_q <= reg_wdata[level_decay_pkg::LOW_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// Attenuation from the attack side; a load in the same tick wins over release,
	// because fresh attack attenuation must never be lost to a release step.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			atten_q <= level_decay_pkg::RESET_ATTEN;
		end else if (atten_load) begin
			atten_q <= atten_in;
		end else if (sample_tick) begin
			atten_q <= release_step(atten_q, rate_q);
		end
	end

	// The active filter sees staged values only on a commit pulse.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			act_b1_q <= '0;
			act_b2_q <= '0;
			act_a1_q <= '0;
			act_a2_q <= '0;
		end else if (coef_commit) begin
			act_b1_q <= join_coef(b1_up_q, b1_lo_q);
			act_b2_q <= join_coef(b2_up_q, b2_lo_q);
			act_a1_q <= join_coef(a1_up_q, a1_lo_q);
			act_a2_q <= join_coef(a2_up_q, a2_lo_q);
		end
	end

	// Read decode; unmapped addresses return zero.
	always_comb begin
		rdata_d = level_decay_pkg::READ_UNMAPPED;
		case (reg_addr)
			level_decay_pkg::ADDR_RELEASE_RATE: rdata_d = {4'h0, rate_q};
			level_decay_pkg::ADDR_B1_UPPER: rdata_d = b1_up_q;
			level_decay_pkg::ADDR_B1_LOWER: rdata_d = low_word(b1_lo_q);
			level_decay_pkg::ADDR_B2_UPPER: rdata_d = b2_up_q;
			level_decay_pkg::ADDR_B2_LOWER: rdata_d = low_word(b2_lo_q);
			level_decay_pkg::ADDR_A1_UPPER: rdata_d = a1_up_q;
			level_decay_pkg::ADDR_A1_LOWER: rdata_d = low_word(a1_lo_q);
			level_decay_pkg::ADDR_A2_UPPER: rdata_d = a2_up_q;
			level_decay_pkg::ADDR_A2_LOWER: rdata_d = low_word(a2_lo_q);
			level_decay_pkg::ADDR_ATTEN_STATUS: rdata_d = atten_q[level_decay_pkg::ATTEN_W-1 -: 16];
			default: rdata_d = level_decay_pkg::READ_UNMAPPED;
		endcase
	end

	// Read data stand only in the cycle after the strobe, zero otherwise.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= level_decay_pkg::READ_UNMAPPED;
		end else if (reg_rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= level_decay_pkg::READ_UNMAPPED;
		end
	end

	sequence s_rate_write;
		reg_wr && reg_addr == level_decay_pkg::ADDR_RELEASE_RATE;
	endsequence

	sequence s_rate_read;
		reg_rd && reg_addr == level_decay_pkg::ADDR_RELEASE_RATE;
	endsequence

	a_rate_readback: assert property (@(posedge mclk) disable iff (sys_rst)
		s_rate_write ##1 s_rate_read |=> reg_rdata == {4'h0, $past(reg_wdata[11:0], 2)})
		else $error("release rate did not read back as written");

	a_release_step: assert property (@(posedge mclk) disable iff (sys_rst)
		sample_tick && !atten_load |=>
		atten_out == $past(atten_q) - 24'(({12'h000, $past(atten_q)} * {24'h000000, $past(rate_q)}) >> 23))
		else $error("release step did not follow the rate coefficient");

	a_release_idle: assert property (@(posedge mclk) disable iff (sys_rst)
		!sample_tick && !atten_load |=> $stable(atten_out))
		else $error("attenuation moved without a sample tick");

	a_upper_full: assert property (@(posedge mclk) disable iff (sys_rst)
		reg_wr && reg_addr == level_decay_pkg::ADDR_B1_UPPER ##1
		reg_rd && reg_addr == level_decay_pkg::ADDR_B1_UPPER |=> reg_rdata == $past(reg_wdata, 2))
		else $error("upper half did not keep sixteen bits");

	a_lower_resvd: assert property (@(posedge mclk) disable iff (sys_rst)
		reg_rd && (reg_addr == level_decay_pkg::ADDR_A2_LOWER || reg_addr == level_decay_pkg::ADDR_B2_LOWER)
		|=> reg_rdata[15:4] == 12'h000)
		else $error("reserved bits of a lower half read nonzero");

	a_commit_load: assert property (@(posedge mclk) disable iff (sys_rst)
		coef_commit |=> active_a1 == {$past(a1_up_q), $past(a1_lo_q)})
		else $error("commit did not load the staged coefficient");

	a_active_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!coef_commit |=> $stable(active_b1) && $stable(active_a2))
		else $error("active coefficient changed without commit");

	sequence s_b2_up_write;
		reg_wr && reg_addr == level_decay_pkg::ADDR_B2_UPPER;
	endsequence

	sequence s_b2_up_read;
		reg_rd && reg_addr == level_decay_pkg::ADDR_B2_UPPER;
	endsequence

	sequence s_a1_up_write;
		reg_wr && reg_addr == level_decay_pkg::ADDR_A1_UPPER;
	endsequence

	sequence s_a1_up_read;
		reg_rd && reg_addr == level_decay_pkg::ADDR_A1_UPPER;
	endsequence

	sequence s_a2_up_write;
		reg_wr && reg_addr == level_decay_pkg::ADDR_A2_UPPER;
	endsequence

	sequence s_a2_up_read;
		reg_rd && reg_addr == level_decay_pkg::ADDR_A2_UPPER;
	endsequence

	sequence s_b1_lo_write;
		reg_wr && reg_addr == level_decay_pkg::ADDR_B1_LOWER;
	endsequence

	sequence s_b1_lo_read;
		reg_rd && reg_addr == level_decay_pkg::ADDR_B1_LOWER;
	endsequence

	sequence s_a1_lo_write;
		reg_wr && reg_addr == level_decay_pkg::ADDR_A1_LOWER;
	endsequence

	sequence s_a1_lo_read;
		reg_rd && reg_addr == level_decay_pkg::ADDR_A1_LOWER;
	endsequence

	a_b2_upper_full: assert property (@(posedge mclk) disable iff (sys_rst)
		s_b2_up_write ##1 s_b2_up_read |=> reg_rdata == $past(reg_wdata, 2))
		else $error("upper half of b2 did not keep sixteen bits");

	a_a1_upper_full: assert property (@(posedge mclk) disable iff (sys_rst)
		s_a1_up_write ##1 s_a1_up_read |=> reg_rdata == $past(reg_wdata, 2))
		else $error("upper half of a1 did not keep sixteen bits");

	a_a2_upper_full: assert property (@(posedge mclk) disable iff (sys_rst)
		s_a2_up_write ##1 s_a2_up_read |=> reg_rdata == $past(reg_wdata, 2))
		else $error("upper half of a2 did not keep sixteen bits");

	a_b1_lower_keep: assert property (@(posedge mclk) disable iff (sys_rst)
		s_b1_lo_write ##1 s_b1_lo_read |=> reg_rdata == {12'h000, $past(reg_wdata[3:0], 2)})
		else $error("lower half of b1 did not keep its four bits");

	a_a1_lower_keep: assert property (@(posedge mclk) disable iff (sys_rst)
		s_a1_lo_write ##1 s_a1_lo_read |=> reg_rdata == {12'h000, $past(reg_wdata[3:0], 2)})
		else $error("lower half of a1 did not keep its four bits");

	a_rate_resvd: assert property (@(posedge mclk) disable iff (sys_rst)
		s_rate_read |=> reg_rdata[15:12] == 4'h0)
		else $error("reserved bits of the release rate read nonzero");

	// Attack attenuation loaded in the same tick as a release step must win.
	a_load_wins: assert property (@(posedge mclk) disable iff (sys_rst)
		atten_load |=> atten_out == $past(atten_in))
		else $error("attenuation load was not taken");

	a_release_bound: assert property (@(posedge mclk) disable iff (sys_rst)
		sample_tick && !atten_load |=> atten_out <= $past(atten_out))
		else $error("release step raised the attenuation");

	a_rate_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!(reg_wr && reg_addr == level_decay_pkg::ADDR_RELEASE_RATE) |=> $stable(rate_q))
		else $error("release rate changed without a write");

	a_upper_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!(reg_wr && reg_addr == level_decay_pkg::ADDR_B1_UPPER) |=> $stable(b1_up_q))
		else $error("upper half of b1 changed without a write");

	a_lower_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!(reg_wr && reg_addr == level_decay_pkg::ADDR_A2_LOWER) |=> $stable(a2_lo_q))
		else $error("lower half of a2 changed without a write");

	a_commit_b1: assert property (@(posedge mclk) disable iff (sys_rst)
		coef_commit |=> active_b1 == {$past(b1_up_q), $past(b1_lo_q)})
		else $error("commit did not load the staged b1 coefficient");

	a_commit_b2: assert property (@(posedge mclk) disable iff (sys_rst)
		coef_commit |=> active_b2 == {$past(b2_up_q), $past(b2_lo_q)})
		else $error("commit did not load the staged b2 coefficient");

	a_commit_a2: assert property (@(posedge mclk) disable iff (sys_rst)
		coef_commit |=> active_a2 == {$past(a2_up_q), $past(a2_lo_q)})
		else $error("commit did not load the staged a2 coefficient");

	a_active_keep: assert property (@(posedge mclk) disable iff (sys_rst)
		!coef_commit |=> $stable(active_b2) && $stable(active_a1))
		else $error("active b2 or a1 changed without commit");
endmodule : level_decay_and_coef_staging
`default_nettype wire

// ===== verification/level_decay_and_coef_staging_tb.sv
// Self-checking testbench for the release rate and coefficient staging register slice.
`timescale 1ns/10ps
`default_nettype none
module level_decay_and_coef_staging_tb;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic sample_tick = 1'b0;
	logic atten_load = 1'b0;
	logic [23:0] atten_in = 24'h000000;
	logic [23:0] atten_out;
	logic coef_commit = 1'b0;
	logic [19:0] active_b1, active_b2, active_a1, active_a2;
	int errors = 0;
	int n_checks = 0;
	logic [15:0] addrs [9] = '{16'h012a, 16'h012c, 16'h012e, 16'h0130, 16'h0132, 16'h0134,
		16'h0136, 16'h0138, 16'h013a};
	always #20 mclk = ~mclk;
	level_decay_and_coef_staging level_decay_and_coef_staging_inst (.mclk(mclk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sample_tick(sample_tick), .atten_load(atten_load),
		.atten_in(atten_in), .atten_out(atten_out), .coef_commit(coef_commit),
		.active_b1(active_b1), .active_b2(active_b2), .active_a1(active_a1), .active_a2(active_a2));
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic commit);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		coef_commit <= commit;
		@(posedge mclk);
		reg_wr <= 1'b0;
		coef_commit <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk($sformatf("read %h", a), {8'h00, exp}, {8'h00, reg_rdata});
	endtask : rd
	task automatic wr_rd(input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk($sformatf("readback %h", a), {8'h00, exp}, {8'h00, reg_rdata});
	endtask : wr_rd
	task automatic commit_now();
		@(posedge mclk);
		coef_commit <= 1'b1;
		@(posedge mclk);
		coef_commit <= 1'b0;
		#1;
	endtask : commit_now
	task automatic test_reset_values();
		for (int i = 0; i < 9; i++) begin
			rd(addrs[i], (i == 0) ? 16'h0050 : 16'h0000);
		end
		rd(16'h0100, 16'h0000);
		$display("reset values done");
	endtask : test_reset_values
	task automatic test_field_widths();
		for (int i = 0; i < 9; i++) begin
			wr_rd(addrs[i], 16'hffff,
				(i == 0) ? 16'h0fff : (i % 2 == 1) ? 16'hffff : 16'h000f);
		end
		wr(16'h0100, 16'h5a5a, 1'b0);
		rd(16'h0100, 16'h0000);
		$display("field widths done");
	endtask : test_field_widths
	task automatic test_commit();
		logic [15:0] up [4] = '{16'habcd, 16'h1234, 16'h8001, 16'h7ffe};
		logic [3:0] lo [4] = '{4'h5, 4'h6, 4'h9, 4'ha};
		for (int i = 0; i < 4; i++) begin
			wr(addrs[2*i+1], up[i], 1'b0);
			wr(addrs[2*i+2], {12'hfff, lo[i]}, 1'b0);
		end
		#1 chk("b1 before commit", 24'h000000, {4'h0, active_b1});
		commit_now();
		chk("b1", {4'h0, up[0], lo[0]}, {4'h0, active_b1});
		chk("b2", {4'h0, up[1], lo[1]}, {4'h0, active_b2});
		chk("a1", {4'h0, up[2], lo[2]}, {4'h0, active_a1});
		chk("a2", {4'h0, up[3], lo[3]}, {4'h0, active_a2});
		wr(addrs[1], 16'h0f0f, 1'b1);
		#1 chk("b1 same-cycle commit", {4'h0, up[0], lo[0]}, {4'h0, active_b1});
		commit_now();
		chk("b1 recommit", {4'h0, 16'h0f0f, lo[0]}, {4'h0, active_b1});
		$display("commit done");
	endtask : test_commit
	task automatic release_step(input logic [11:0] rate, input logic [23:0] start);
		logic [35:0] prod;
		logic [23:0] want;
		prod = {12'h000, start} * {24'h000000, rate};
		want = start - prod[35:23];
		wr(addrs[0], {4'hf, rate}, 1'b0);
		@(posedge mclk);
		atten_load <= 1'b1;
		sample_tick <= 1'b1;
		atten_in <= start;
		@(posedge mclk);
		atten_load <= 1'b0;
		@(posedge mclk);
		sample_tick <= 1'b0;
		#1 chk("atten after tick", want, atten_out);
		rd(16'h013c, want[23:8]);
	endtask : release_step
	task automatic test_release();
		release_step(12'h050, 24'h800000);
		release_step(12'hfff, 24'hffffff);
		release_step(12'h284, 24'h123456);
		@(posedge mclk);
		#1 chk("atten holds without tick", 24'h1233fb, atten_out);
		$display("release done");
	endtask : test_release
	task automatic test_mid_reset();
		wr(addrs[0], 16'h0123, 1'b0);
		wr(addrs[1], 16'h4321, 1'b1);
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		#1 chk("atten after reset", 24'h000000, atten_out);
		chk("b1 after reset", 24'h000000, {4'h0, active_b1});
		rd(addrs[0], 16'h0050);
		rd(addrs[1], 16'h0000);
		$display("mid-run reset done");
	endtask : test_mid_reset
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		test_reset_values();
		test_field_widths();
		test_commit();
		test_release();
		test_mid_reset();
		finish_test();
	end
endmodule : level_decay_and_coef_staging_tb
`default_nettype wire
